// file: src/drq_tracker.sv
// data holding register, data request line and lost-data detection
`default_nettype none
`include "fdc_status_params.svh"
module drq_tracker
(
	input  wire logic       sys_clk,
	input  wire logic       srst,
	input  wire logic       start,
	input  wire logic       write_mode,
	input  wire logic       active,
	input  wire logic       byte_tick,
	input  wire logic [7:0] rx_byte,
	input  wire logic       host_rd,
	input  wire logic       host_wr,
	input  wire logic [7:0] host_wdata,
	output logic            data_request_line,
	output logic            lost,
	output logic            lost_pulse,
	output logic      [7:0] holding,
	output logic      [7:0] tx_byte
);
	logic serviced;
	logic missed;

	// an access in the same cycle as the byte tick still counts as in time
	assign serviced = write_mode ? host_wr : host_rd;
	assign missed   = data_request_line & ~serviced;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			data_request_line <= 1'b0;
			lost              <= 1'b0;
			lost_pulse        <= 1'b0;
			holding           <= `BYTE_RESET;
			tx_byte           <= `BYTE_RESET;
		end
		else
		begin
			lost_pulse <= 1'b0;
			if (host_wr && write_mode)
				holding <= host_wdata;
			if (start)
			begin
				data_request_line <= write_mode;
				lost              <= 1'b0;
			end
			else if (active && byte_tick)
			begin
				data_request_line <= 1'b1;
				lost              <= lost | missed;
				lost_pulse        <= missed;
				if (!write_mode)
					holding <= rx_byte;
				else if (host_wr)
					tx_byte <= host_wdata;
				else
					tx_byte <= missed ? `FILL_BYTE : holding;
			end
			else if (serviced || (!active && write_mode))
				data_request_line <= 1'b0;
		end
	end
endmodule // drq_tracker
`default_nettype wire

// file: src/fdc_status_params.svh
// constants of the floppy read/write command status block
//
// Summary of operation
// - not-ready bit is inverted ready ORed with reset
// - no sector/track/address command while drive unready
// - write-protect on writes only, cleared on update
// - sector read reports deleted versus normal mark
// - writes report drive write fault, cleared on update
// - record-missing set when target not found
// - crc error refers to id or data field
// - lost data when host misses one byte time
// - data-request bit mirrors the data request line
// - busy set throughout command execution
`ifndef FDC_STATUS_PARAMS_SVH
`define FDC_STATUS_PARAMS_SVH

`define ADDR_STATUS     4'h0
`define ADDR_DATA       4'h1
`define ADDR_IRQ_STATUS 4'h2
`define ADDR_IRQ_ENABLE 4'h3
`define ADDR_IRQ_CLEAR  4'h4

`define BIT_NOT_READY 7
`define BIT_PROTECT   6
`define BIT_KIND      5
`define BIT_MISSING   4
`define BIT_CRC       3
`define BIT_LOST      2
`define BIT_DRQ       1
`define BIT_BUSY      0

`define CMD_FIELD_HI 7
`define CMD_FIELD_LO 5

`define IRQ_DONE    0
`define IRQ_REFUSED 1
`define IRQ_LOST    2
`define IRQ_WIDTH   3
`define IRQ_EN_RESET 3'h0

`define PIN_COUNT  4
`define PIN_READY  0
`define PIN_MR     1
`define PIN_WPROT  2
`define PIN_WFAULT 3

`define BYTE_RESET 8'h00
`define FILL_BYTE  8'h00

`endif

// file: src/fdc_status_pkg.sv
// types shared by the floppy read/write command status block
`default_nettype none
package fdc_status_pkg;
	typedef enum logic [2:0] {
		CMD_NONE         = 3'h0,
		CMD_READ_SECTOR  = 3'h1,
		CMD_WRITE_SECTOR = 3'h2,
		CMD_READ_TRACK   = 3'h3,
		CMD_WRITE_TRACK  = 3'h4,
		CMD_READ_ADDRESS = 3'h5
	} cmd_kind_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01
	} state_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic       byte_tick;
		logic [7:0] rx_byte;
		logic       id_missing;
		logic       crc_fail;
		logic       deleted_mark;
		logic       done;
	} disk_evt_t;
endpackage
`default_nettype wire

// file: src/floppy_rw_command_status.sv
// command sequencing and status register of the floppy read/write path
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`default_nettype none
`include "fdc_status_params.svh"
module floppy_rw_command_status
(
	input  wire logic                     sys_clk,
	input  wire logic                     srst,
	input  wire fdc_status_pkg::reg_req_t req,
	output logic                    [7:0] rd_data,
	input  wire logic                     drive_ready,
	input  wire logic                     master_reset_input,
	input  wire logic                     write_protect,
	input  wire logic                     write_fault,
	input  wire fdc_status_pkg::disk_evt_t evt,
	output logic                          data_request_line,
	output logic                    [7:0] disk_tx_byte,
	output logic                          busy,
	output logic                          irq
);
	import fdc_status_pkg::*;

	logic [`PIN_COUNT-1:0] pins_async;
	logic [`PIN_COUNT-1:0] pins_synced;
	logic                  ready_s;
	logic                  mr_s;
	logic                  wprot_s;
	logic                  wfault_s;
	logic                  not_ready;
	state_t                state_reg;
	cmd_kind_t             kind_reg;
	cmd_kind_t             cmd_code;
	logic                  cmd_wr;
	logic                  legal;
	logic                  idle;
	logic                  start;
	logic                  refuse;
	logic                  new_is_write;
	logic                  run_is_write;
	logic                  wp_abort;
	logic                  drq_write_mode;
	logic                  done_pulse;
	logic                  addr_kind;
	logic                  protect_reg;
	logic                  kind_bit_reg;
	logic                  missing_reg;
	logic                  crc_reg;
	logic                  lost;
	logic                  lost_pulse;
	logic [7:0]            holding;
	logic [7:0]            status_value;
	logic [`IRQ_WIDTH-1:0] irq_status_reg;
	logic [`IRQ_WIDTH-1:0] irq_enable_reg;
	logic [`IRQ_WIDTH-1:0] irq_events;
	logic [`IRQ_WIDTH-1:0] irq_clear;
	logic [7:0]            rd_data_next;

	assign pins_async[`PIN_READY]  = drive_ready;
	assign pins_async[`PIN_MR]     = master_reset_input;
	assign pins_async[`PIN_WPROT]  = write_protect;
	assign pins_async[`PIN_WFAULT] = write_fault;

	pin_sync i_pin_sync
	(
		.sys_clk    (sys_clk),
		.srst       (srst),
		.pin_async  (pins_async),
		.pin_synced (pins_synced)
	);

	assign ready_s  = pins_synced[`PIN_READY];
	assign mr_s     = pins_synced[`PIN_MR];
	assign wprot_s  = pins_synced[`PIN_WPROT];
	assign wfault_s = pins_synced[`PIN_WFAULT];

	assign not_ready = ~ready_s | mr_s;

	// command decode
	assign cmd_wr   = req.wr && (req.addr == `ADDR_STATUS);
	assign cmd_code = cmd_kind_t'(req.wdata[`CMD_FIELD_HI:`CMD_FIELD_LO]);
	assign legal    = (cmd_code == CMD_READ_SECTOR) || (cmd_code == CMD_WRITE_SECTOR)
		|| (cmd_code == CMD_READ_TRACK) || (cmd_code == CMD_WRITE_TRACK)
		|| (cmd_code == CMD_READ_ADDRESS);
	assign idle     = (state_reg == ST_IDLE);
	// a command written while one runs is ignored rather than queued
	assign start    = cmd_wr && legal && idle && !not_ready;
	assign refuse   = cmd_wr && legal && idle && not_ready;

	assign new_is_write = (cmd_code == CMD_WRITE_SECTOR) || (cmd_code == CMD_WRITE_TRACK);
	assign run_is_write = (kind_reg == CMD_WRITE_SECTOR) || (kind_reg == CMD_WRITE_TRACK);
	// a protected disk ends a write at once, with the protect bit left set
	assign wp_abort     = start && new_is_write && wprot_s;
	// an aborted write must not raise the data request for a command that never runs
	assign drq_write_mode = start ? (new_is_write && !wprot_s) : run_is_write;
	assign done_pulse   = ((state_reg == ST_RUN) && evt.done) || wp_abort;
	// track commands carry no id search, so missing and crc stay zero
	assign addr_kind    = (kind_reg == CMD_READ_SECTOR) || (kind_reg == CMD_WRITE_SECTOR)
		|| (kind_reg == CMD_READ_ADDRESS);

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			state_reg <= ST_IDLE;
			kind_reg  <= CMD_NONE;
		end
		else
		begin
			unique case (state_reg)
				ST_IDLE:
				begin
					if (start)
					begin
						kind_reg <= cmd_code;
						if (!wp_abort)
							state_reg <= ST_RUN;
					end
				end
				ST_RUN:
				begin
					if (evt.done)
						state_reg <= ST_IDLE;
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// busy has its own flop so the pin never shows a decode glitch
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			busy <= 1'b0;
		else if (start && !wp_abort)
			busy <= 1'b1;
		else if (busy && evt.done)
			busy <= 1'b0;
	end

	// error bits: start of a command is the status update that clears them
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			protect_reg <= 1'b0;
		else if (start)
			protect_reg <= new_is_write & wprot_s;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst || start)
			kind_bit_reg <= 1'b0;
		else if (busy && (kind_reg == CMD_READ_SECTOR) && evt.deleted_mark)
			kind_bit_reg <= 1'b1;
		else if (busy && run_is_write && wfault_s)
			kind_bit_reg <= 1'b1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst || start)
			missing_reg <= 1'b0;
		else if (busy && addr_kind && evt.id_missing)
			missing_reg <= 1'b1;
	end

	// with missing set the crc bit speaks of id fields, else of data
	always_ff @(posedge sys_clk)
	begin
		if (srst || start)
			crc_reg <= 1'b0;
		else if (busy && addr_kind && evt.crc_fail)
			crc_reg <= 1'b1;
	end

	drq_tracker i_drq_tracker
	(
		.sys_clk           (sys_clk),
		.srst              (srst),
		.start             (start),
		.write_mode        (drq_write_mode),
		.active            (busy),
		.byte_tick         (evt.byte_tick),
		.rx_byte           (evt.rx_byte),
		.host_rd           (req.rd && (req.addr == `ADDR_DATA)),
		.host_wr           (req.wr && (req.addr == `ADDR_DATA)),
		.host_wdata        (req.wdata),
		.data_request_line (data_request_line),
		.lost              (lost),
		.lost_pulse        (lost_pulse),
		.holding           (holding),
		.tx_byte           (disk_tx_byte)
	);

	always_comb
	begin
		status_value                 = 8'h00;
		status_value[`BIT_NOT_READY] = not_ready;
		status_value[`BIT_PROTECT]   = protect_reg;
		status_value[`BIT_KIND]      = kind_bit_reg;
		status_value[`BIT_MISSING]   = missing_reg;
		status_value[`BIT_CRC]       = crc_reg;
		status_value[`BIT_LOST]      = lost;
		status_value[`BIT_DRQ]       = data_request_line;
		status_value[`BIT_BUSY]      = busy;
	end

	// interrupt status: set wins over a clear in the same cycle
	always_comb
	begin
		irq_events               = '0;
		irq_events[`IRQ_DONE]    = done_pulse;
		irq_events[`IRQ_REFUSED] = refuse;
		irq_events[`IRQ_LOST]    = lost_pulse;
		irq_clear                = '0;
		if (req.wr && (req.addr == `ADDR_IRQ_CLEAR))
			irq_clear = req.wdata[`IRQ_WIDTH-1:0];
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			irq_status_reg <= '0;
		else
			irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			irq_enable_reg <= `IRQ_EN_RESET;
		else if (req.wr && (req.addr == `ADDR_IRQ_ENABLE))
			irq_enable_reg <= req.wdata[`IRQ_WIDTH-1:0];
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			irq <= 1'b0;
		else
			irq <= |(((irq_status_reg & ~irq_clear) | irq_events) & irq_enable_reg);
	end

	// read port: unmapped addresses and write-only registers read zero
	always_comb
	begin
		rd_data_next = 8'h00;
		unique case (req.addr)
			`ADDR_STATUS:     rd_data_next = status_value;
			`ADDR_DATA:       rd_data_next = holding;
			`ADDR_IRQ_STATUS: rd_data_next = {5'h00, irq_status_reg};
			`ADDR_IRQ_ENABLE: rd_data_next = {5'h00, irq_enable_reg};
			default:          rd_data_next = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			rd_data <= 8'h00;
		else if (req.rd)
			rd_data <= rd_data_next;
		else
			rd_data <= 8'h00;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	a_not_ready_read: assert property (
		req.rd && (req.addr == `ADDR_STATUS)
		|=> rd_data[`BIT_NOT_READY] == $past(not_ready))
		else $error("not-ready bit does not follow ready and master reset");

	a_unready_refuse: assert property (
		cmd_wr && legal && idle && not_ready |=> !busy ##1 !busy)
		else $error("command started while drive not ready");

	a_protect_reads_zero: assert property (
		busy && !run_is_write |-> !protect_reg)
		else $error("write-protect bit set during a read command");

	a_deleted_mark_kind: assert property (
		busy && (kind_reg == CMD_READ_SECTOR) && evt.deleted_mark && !evt.done
		|=> kind_bit_reg)
		else $error("deleted mark not reported");

	a_write_fault_kind: assert property (
		busy && run_is_write && wfault_s |=> kind_bit_reg)
		else $error("write fault not reported");

	a_missing_track: assert property (
		busy && ((kind_reg == CMD_READ_TRACK) || (kind_reg == CMD_WRITE_TRACK))
		|-> !missing_reg && !crc_reg)
		else $error("record-missing or crc set on a track command");

	a_update_clears: assert property (
		start |=> !crc_reg && !missing_reg && !kind_bit_reg)
		else $error("error bits not cleared at status update");

	a_lost_on_miss: assert property (
		busy && evt.byte_tick && data_request_line && !start
		&& !(req.rd && (req.addr == `ADDR_DATA)) && !run_is_write
		|=> lost)
		else $error("missed data request did not raise lost data");

	a_drq_mirror: assert property (
		req.rd && (req.addr == `ADDR_STATUS)
		|=> rd_data[`BIT_DRQ] == $past(data_request_line))
		else $error("data-request bit differs from the data request line");

	a_busy_start: assert property (
		start && !wp_abort |=> busy)
		else $error("busy did not rise at command start");

	a_busy_span: assert property (
		busy && !evt.done |=> busy)
		else $error("busy dropped before the command finished");

	a_done_clears_busy: assert property (
		busy && evt.done |=> !busy)
		else $error("busy stays set after the command finished");

	a_refuse_flagged: assert property (
		refuse |=> irq_status_reg[`IRQ_REFUSED])
		else $error("refused command not flagged");

	a_protect_write: assert property (
		start && new_is_write && wprot_s |=> protect_reg)
		else $error("write-protect bit not set on a protected write");

	a_abort_no_drq: assert property (
		wp_abort |=> !data_request_line)
		else $error("data request raised for an aborted write");

	a_lost_cleared: assert property (
		start |=> !lost)
		else $error("lost-data bit not cleared at status update");

	a_tick_sets_drq: assert property (
		busy && evt.byte_tick && !start |=> data_request_line)
		else $error("byte time did not raise the data request");

	a_busy_ignores_cmd: assert property (
		cmd_wr && !idle |=> $stable(kind_reg))
		else $error("command accepted while another one runs");
endmodule // floppy_rw_command_status
`default_nettype wire

// file: src/pin_sync.sv
// two-stage synchroniser for the drive pins
`default_nettype none
`include "fdc_status_params.svh"
module pin_sync
(
	input  wire logic                  sys_clk,
	input  wire logic                  srst,
	input  wire logic [`PIN_COUNT-1:0] pin_async,
	output logic      [`PIN_COUNT-1:0] pin_synced
);
	genvar i;
	generate
		for (i = 0; i < `PIN_COUNT; i++)
		begin : g_bit
			logic stage1_reg;
			always_ff @(posedge sys_clk)
			begin
				if (srst)
				begin
					stage1_reg    <= 1'b0;
					pin_synced[i] <= 1'b0;
				end
				else
				begin
					stage1_reg    <= pin_async[i];
					pin_synced[i] <= stage1_reg;
				end
			end
		end
	endgenerate
endmodule // pin_sync
`default_nettype wire

// file: verif/host_model.sv
// host processor model that drives the register port of the status block
`default_nettype none
module host_model
	import fdc_status_pkg::*;
(
	input  wire logic       sys_clk,
	output var  reg_req_t   req,
	input  wire logic [7:0] rd_data
);
	timeunit 1ns;
	timeprecision 1ps;

	initial req = '0;

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		req.addr  <= a;
		req.wdata <= d;
		req.wr    <= 1'b1;
		@(posedge sys_clk);
		req.wr    <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, so sample just past that edge
	// one data read or write per request, well inside a byte time
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		req.addr <= a;
		req.rd   <= 1'b1;
		@(posedge sys_clk);
		req.rd   <= 1'b0;
		#1;
		d = rd_data;
	endtask
endmodule // host_model
`default_nettype wire

// file: verif/tb_floppy_rw_command_status.sv
// self-checking bench of the floppy read/write command status block
`default_nettype none
module tb_floppy_rw_command_status
	import fdc_status_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic       sys_clk;
	logic       srst;
	reg_req_t   req;
	logic [7:0] rd_data;
	logic       drive_ready;
	logic       master_reset_input;
	logic       write_protect;
	logic       write_fault;
	disk_evt_t  evt;
	logic       data_request_line;
	logic [7:0] disk_tx_byte;
	logic       busy;
	logic       irq;
	logic [7:0] v;
	int         fail_count;
	int         compares;

	floppy_rw_command_status i_floppy_rw_command_status (
		.sys_clk            (sys_clk),
		.srst               (srst),
		.req                (req),
		.rd_data            (rd_data),
		.drive_ready        (drive_ready),
		.master_reset_input (master_reset_input),
		.write_protect      (write_protect),
		.write_fault        (write_fault),
		.evt                (evt),
		.data_request_line  (data_request_line),
		.disk_tx_byte       (disk_tx_byte),
		.busy               (busy),
		.irq                (irq)
	);

	host_model i_host_model (
		.sys_clk (sys_clk),
		.req     (req),
		.rd_data (rd_data)
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		#1;
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
		i_host_model.rd(a, v);
		check(v, exp);
	endtask

	// one-cycle disk engine event
	task automatic ev(input disk_evt_t e);
		@(posedge sys_clk);
		evt <= e;
		@(posedge sys_clk);
		evt <= '0;
	endtask

	// watchdog: a hang counts as a mismatch
	initial
	begin
		#1ms;
		fail_count++;
		stop_test();
	end

	initial
	begin
		fail_count = 0;
		compares = 0;
		srst = 1'b1;
		drive_ready = 1'b0;
		master_reset_input = 1'b0;
		write_protect = 1'b0;
		write_fault = 1'b0;
		evt = '0;
		step(12);
		srst <= 1'b0;
		rdchk(4'h0, 8'h80);
		i_host_model.wr(4'h3, 8'h07);
		i_host_model.wr(4'h0, 8'h20);
		step(3);
		check({7'h0, busy}, 8'h00);
		rdchk(4'h2, 8'h02);
		check({7'h0, irq}, 8'h01);
		i_host_model.wr(4'h4, 8'h02);
		step(2);
		check({7'h0, irq}, 8'h00);
		rdchk(4'h2, 8'h00);
		step(1);
		drive_ready <= 1'b1;
		step(4);
		rdchk(4'h0, 8'h00);
		step(1);
		master_reset_input <= 1'b1;
		step(4);
		rdchk(4'h0, 8'h80);
		step(1);
		master_reset_input <= 1'b0;
		step(4);
		$display("test not_ready ended");

		i_host_model.wr(4'h0, 8'h40);
		step(1);
		check({7'h0, busy}, 8'h01);
		rdchk(4'h0, 8'h03);
		i_host_model.wr(4'h1, 8'h5a);
		ev({1'b1, 8'h00, 4'h0});
		step(1);
		check(disk_tx_byte, 8'h5a);
		write_fault <= 1'b1;
		step(4);
		write_fault <= 1'b0;
		ev({12'h000, 1'b1});
		step(2);
		rdchk(4'h0, 8'h20);
		i_host_model.wr(4'h4, 8'h07);
		$display("test write_fault ended");

		step(1);
		write_protect <= 1'b1;
		step(4);
		i_host_model.wr(4'h0, 8'h80);
		step(3);
		check({7'h0, busy}, 8'h00);
		i_host_model.rd(4'h0, v);
		check(v & 8'h40, 8'h40);
		$display("test protect ended");

		i_host_model.wr(4'h0, 8'h20);
		step(1);
		rdchk(4'h0, 8'h01);
		ev({1'b1, 8'ha5, 4'h0});
		step(1);
		check({7'h0, data_request_line}, 8'h01);
		rdchk(4'h0, 8'h03);
		rdchk(4'h1, 8'ha5);
		check({7'h0, data_request_line}, 8'h00);
		ev({9'h000, 4'b1110});
		ev({12'h000, 1'b1});
		step(2);
		rdchk(4'h0, 8'h38);
		check({7'h0, irq}, 8'h01);
		step(1);
		write_protect <= 1'b0;
		$display("test read_sector ended");

		i_host_model.wr(4'h4, 8'h07);
		i_host_model.wr(4'h0, 8'h60);
		ev({1'b1, 8'h11, 4'h0});
		ev({1'b1, 8'h22, 4'h0});
		step(1);
		rdchk(4'h0, 8'h07);
		rdchk(4'h2, 8'h04);
		ev({12'h000, 1'b1});
		step(2);
		check({7'h0, busy}, 8'h00);
		rdchk(4'h0, 8'h06);
		$display("test lost_data ended");

		i_host_model.wr(4'h4, 8'h07);
		i_host_model.wr(4'h0, 8'he0);
		step(2);
		check({7'h0, busy}, 8'h00);
		rdchk(4'h2, 8'h00);
		rdchk(4'h0, 8'h06);
		i_host_model.wr(4'h0, 8'ha0);
		ev({9'h000, 4'b1110});
		ev({12'h000, 1'b1});
		step(2);
		rdchk(4'h0, 8'h18);
		i_host_model.wr(4'h0, 8'h60);
		ev({9'h000, 4'b1110});
		ev({12'h000, 1'b1});
		step(2);
		rdchk(4'h0, 8'h00);
		rdchk(4'h2, 8'h01);
		$display("test decode ended");
		stop_test();
	end
endmodule // tb_floppy_rw_command_status
`default_nettype wire
